// ===== logic/timer_irq_flags.sv
// Flags, masks, capture registers and interrupt requests of two timers
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Capture event copies counter to capture register
// - Capture register may serve as top
// - Low byte read latches high byte
// - Request needs enable, global flag, flag
// - Unit 1 enables at 7,6,5,3, reset zero
// - Unit 3 enables at 5,4,3,2
// - Unit 1 flags at 7,6,5,3, reset zero
// - Unit 3 flags at 5,4,3,2
// - Wrap flag set on counter overflow
// - Match flag set cycle after equality
// - Forced compare never sets match flag
// - Capture flag on event, or at top
// - Vector execution clears its flag (code clears it only by a one written to the flag or ack register)
// - Writing one clears flag, zero keeps
// - Edge select: zero falling, one rising
// - Filter needs four equal samples
// - Capture pin off while capture is top
module timer_irq_flags
   import tmr_irq_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Capture inputs
   input wire logic capture_pin_u1,
   input wire logic capture_pin_u3,
   input wire logic comparator_out,
   // Counter core events
   input wire logic [WIDTH-1:0] counter_value_u1,
   input wire logic [WIDTH-1:0] counter_value_u3,
   input wire unit_events_t events_u1,
   input wire unit_events_t events_u3,
   // CPU interrupt side and top values to the counter
   input wire logic global_irq_en,
   output logic [7:0] irq_req,
   output logic irq,
   output logic [WIDTH-1:0] top_value_u1,
   output logic [WIDTH-1:0] top_value_u3
);
   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   logic [7:0] timer_irq_mask;
   logic [7:0] timer_irq_mask_extended;
   logic [7:0] timer_irq_flags;
   logic [7:0] timer_irq_flags_extended;
   logic [2:0] ctrl_u1;
   logic [2:0] ctrl_u3;
   logic [7:0] temp_high;
   logic [WIDTH-1:0] capture_value_unit1;
   logic [WIDTH-1:0] capture_value_unit3;
   logic [3:0] set_u1;
   logic [3:0] set_u3;
   logic cap_ev_u1;
   logic cap_ev_u3;
   logic src_u1;
   logic [7:0] set_main;
   logic [7:0] set_ext;
   logic [7:0] clr_main;
   logic [7:0] clr_ext;
   logic [7:0] next_flags;
   logic [7:0] next_flags_ext;
   logic [7:0] pend_main;
   logic [7:0] pend_ext;
   logic [7:0] next_req;
   logic [31:0] next_rdata;
   logic next_err;
   logic wr;
   logic rd;
   logic setup;
   logic access;
   logic hit_mask;
   logic hit_mask_ext;
   logic hit_flags;
   logic hit_flags_ext;
   logic hit_cap1_lo;
   logic hit_cap1_hi;
   logic hit_cap3_lo;
   logic hit_cap3_hi;
   logic hit_ctrl1;
   logic hit_ctrl3;
   logic hit_ack;

   // -------------------------------------------------------------------
   // Bus phases and address decode
   // -------------------------------------------------------------------
   // Read data staged at setup; writes commit only at the completing
   // access edge, while a low capture read loads temp_high at setup
   assign setup = psel && !penable;
   assign access = psel && penable && pready;
   assign wr = access && pwrite;
   assign rd = setup && !pwrite;

   always_comb begin
      hit_mask = 1'b0;
      hit_mask_ext = 1'b0;
      hit_flags = 1'b0;
      hit_flags_ext = 1'b0;
      hit_cap1_lo = 1'b0;
      hit_cap1_hi = 1'b0;
      hit_cap3_lo = 1'b0;
      hit_cap3_hi = 1'b0;
      hit_ctrl1 = 1'b0;
      hit_ctrl3 = 1'b0;
      hit_ack = 1'b0;
      if (paddr == ADDR_MASK) begin
         hit_mask = 1'b1;
      end else if (paddr == ADDR_MASK_EXT) begin
         hit_mask_ext = 1'b1;
      end else if (paddr == ADDR_FLAGS) begin
         hit_flags = 1'b1;
      end else if (paddr == ADDR_FLAGS_EXT) begin
         hit_flags_ext = 1'b1;
      end else if (paddr == ADDR_CAP1_LO) begin
         hit_cap1_lo = 1'b1;
      end else if (paddr == ADDR_CAP1_HI) begin
         hit_cap1_hi = 1'b1;
      end else if (paddr == ADDR_CAP3_LO) begin
         hit_cap3_lo = 1'b1;
      end else if (paddr == ADDR_CAP3_HI) begin
         hit_cap3_hi = 1'b1;
      end else if (paddr == ADDR_CTRL1) begin
         hit_ctrl1 = 1'b1;
      end else if (paddr == ADDR_CTRL3) begin
         hit_ctrl3 = 1'b1;
      end else if (paddr == ADDR_ACK) begin
         hit_ack = 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Capture path
   // -------------------------------------------------------------------
   assign src_u1 = ctrl_u1[BIT_COMP_SRC] ? comparator_out : capture_pin_u1;

   capture_filter #(.SAMPLES(FILTER_SAMPLES)) filt_u1 (
      .pclk(pclk),
      .presetn(presetn),
      .filter_en(ctrl_u1[BIT_FILTER]),
      .edge_sel(ctrl_u1[BIT_EDGE]),
      .disable_cap(events_u1.cap_is_top),
      .capture_pin(src_u1),
      .capture_event(cap_ev_u1)
   );

   capture_filter #(.SAMPLES(FILTER_SAMPLES)) filt_u3 (
      .pclk(pclk),
      .presetn(presetn),
      .filter_en(ctrl_u3[BIT_FILTER]),
      .edge_sel(ctrl_u3[BIT_EDGE]),
      .disable_cap(events_u3.cap_is_top),
      .capture_pin(capture_pin_u3),
      .capture_event(cap_ev_u3)
   );

   capture_unit #(.WIDTH(WIDTH)) unit1 (
      .pclk(pclk),
      .presetn(presetn),
      .capture_event(cap_ev_u1),
      .counter_value(counter_value_u1),
      .ev(events_u1),
      .capture_value(capture_value_unit1),
      .set_req(set_u1)
   );

   capture_unit #(.WIDTH(WIDTH)) unit3 (
      .pclk(pclk),
      .presetn(presetn),
      .capture_event(cap_ev_u3),
      .counter_value(counter_value_u3),
      .ev(events_u3),
      .capture_value(capture_value_unit3),
      .set_req(set_u3)
   );

   // Capture register offered to the counter as top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         top_value_u1 <= '0;
         top_value_u3 <= '0;
      end else begin
         top_value_u1 <= capture_value_unit1;
         top_value_u3 <= capture_value_unit3;
      end
   end

   // -------------------------------------------------------------------
   // Flag set and clear
   // -------------------------------------------------------------------
   always_comb begin
      set_main = 8'h00;
      set_ext = 8'h00;
      set_main[BIT_WRAP_U1] = set_u1[3];
      set_main[BIT_MATCH_A_U1] = set_u1[2];
      set_main[BIT_MATCH_B_U1] = set_u1[1];
      set_main[BIT_CAPTURE_U1] = set_u1[0];
      set_ext[BIT_WRAP_U3] = set_u3[3];
      set_ext[BIT_MATCH_A_U3] = set_u3[2];
      set_ext[BIT_MATCH_B_U3] = set_u3[1];
      set_ext[BIT_CAPTURE_U3] = set_u3[0];
   end

   // Vector ack word: low byte main, next byte extended
   always_comb begin
      clr_main = 8'h00;
      clr_ext = 8'h00;
      if (wr && hit_flags) begin
         clr_main = pwdata[7:0];
      end else if (wr && hit_flags_ext) begin
         clr_ext = pwdata[7:0];
      end else if (wr && hit_ack) begin
         clr_main = pwdata[7:0];
         clr_ext = pwdata[15:8];
      end
      // Set listed last so an event in the clear cycle survives
      next_flags = (timer_irq_flags & ~clr_main) | set_main;
      next_flags_ext = (timer_irq_flags_extended & ~clr_ext) | set_ext;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq_flags <= RESET_FLAGS;
         timer_irq_flags_extended <= RESET_FLAGS;
      end else begin
         timer_irq_flags <= next_flags;
         timer_irq_flags_extended <= next_flags_ext;
      end
   end

   // -------------------------------------------------------------------
   // Masks and control
   // -------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq_mask <= RESET_MASK;
         timer_irq_mask_extended <= RESET_MASK;
         ctrl_u1 <= RESET_CTRL;
         ctrl_u3 <= RESET_CTRL;
      end else if (wr) begin
         if (hit_mask) begin
            timer_irq_mask <= pwdata[7:0];
         end else if (hit_mask_ext) begin
            timer_irq_mask_extended <= pwdata[7:0];
         end else if (hit_ctrl1) begin
            ctrl_u1 <= pwdata[2:0];
         end else if (hit_ctrl3) begin
            ctrl_u3 <= pwdata[2:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // Interrupt requests
   // -------------------------------------------------------------------
   // Enable, global flag and flag must all hold
   assign pend_main = timer_irq_mask & timer_irq_flags &
      {8{global_irq_en}};
   assign pend_ext = timer_irq_mask_extended & timer_irq_flags_extended &
      {8{global_irq_en}};

   // Vector lines: unit 1 wrap, a, b, cap, then unit 3 same order
   assign next_req = {pend_main[BIT_WRAP_U1], pend_main[BIT_MATCH_A_U1],
      pend_main[BIT_MATCH_B_U1], pend_main[BIT_CAPTURE_U1],
      pend_ext[BIT_WRAP_U3], pend_ext[BIT_MATCH_A_U3],
      pend_ext[BIT_MATCH_B_U3], pend_ext[BIT_CAPTURE_U3]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req <= 8'h00;
         irq <= 1'b0;
      end else begin
         irq_req <= next_req;
         irq <= |next_req;
      end
   end

   // -------------------------------------------------------------------
   // Read path with shared high-byte latch
   // -------------------------------------------------------------------
   // Low read grabs high byte so a later high read is coherent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_high <= 8'h00;
      end else if (rd && hit_cap1_lo) begin
         temp_high <= capture_value_unit1[15:8];
      end else if (rd && hit_cap3_lo) begin
         temp_high <= capture_value_unit3[15:8];
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (hit_mask) begin
         next_rdata[7:0] = timer_irq_mask;
      end else if (hit_mask_ext) begin
         next_rdata[7:0] = timer_irq_mask_extended;
      end else if (hit_flags) begin
         next_rdata[7:0] = timer_irq_flags;
      end else if (hit_flags_ext) begin
         next_rdata[7:0] = timer_irq_flags_extended;
      end else if (hit_cap1_lo) begin
         next_rdata[7:0] = capture_value_unit1[7:0];
      end else if (hit_cap3_lo) begin
         next_rdata[7:0] = capture_value_unit3[7:0];
      end else if (hit_cap1_hi || hit_cap3_hi) begin
         next_rdata[7:0] = temp_high;
      end else if (hit_ctrl1) begin
         next_rdata[2:0] = ctrl_u1;
      end else if (hit_ctrl3) begin
         next_rdata[2:0] = ctrl_u3;
      end else if (hit_ack) begin
         next_rdata = 32'h0000_0000;
      end else begin
         next_err = 1'b1;
      end
   end

   // No wait state: answer in the first access cycle of every transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && next_err;
         if (rd) begin
            prdata <= next_rdata;
         end
      end
   end
endmodule : timer_irq_flags
`default_nettype wire

// ===== logic/tmr_irq_pkg.sv
// Package: register map, field positions and shared types of the timer flags
package tmr_irq_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses on the APB
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_MASK = 8'h00;
   localparam logic [7:0] ADDR_MASK_EXT = 8'h04;
   localparam logic [7:0] ADDR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_FLAGS_EXT = 8'h0c;
   localparam logic [7:0] ADDR_CAP1_LO = 8'h10;
   localparam logic [7:0] ADDR_CAP1_HI = 8'h14;
   localparam logic [7:0] ADDR_CAP3_LO = 8'h18;
   localparam logic [7:0] ADDR_CAP3_HI = 8'h1c;
   localparam logic [7:0] ADDR_CTRL1 = 8'h20;
   localparam logic [7:0] ADDR_CTRL3 = 8'h24;
   localparam logic [7:0] ADDR_ACK = 8'h28;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_WRAP_U1 = 7;
   localparam int BIT_MATCH_A_U1 = 6;
   localparam int BIT_MATCH_B_U1 = 5;
   localparam int BIT_CAPTURE_U1 = 3;
   localparam int BIT_CAPTURE_U3 = 5;
   localparam int BIT_MATCH_A_U3 = 4;
   localparam int BIT_MATCH_B_U3 = 3;
   localparam int BIT_WRAP_U3 = 2;
   // Control register: edge sel, filter en, comparator source
   localparam int BIT_EDGE = 0;
   localparam int BIT_FILTER = 1;
   localparam int BIT_COMP_SRC = 2;
   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_MASK = 8'h00;
   localparam logic [7:0] RESET_FLAGS = 8'h00;
   localparam logic [2:0] RESET_CTRL = 3'h0;
   localparam int FILTER_SAMPLES = 4;
   // ----------------------------------------------------------------
   // Per-unit timer events from the counter core
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wrap;
      logic match_a;
      logic match_b;
      logic at_top;
      logic cap_is_top;
   } unit_events_t;
endpackage : tmr_irq_pkg

// ===== logic/capture_filter.sv
// Capture input noise filter and edge detector for one timer unit
`timescale 1ns/1ps
`default_nettype none
module capture_filter
   import tmr_irq_pkg::*;
#(
   parameter int SAMPLES = FILTER_SAMPLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic filter_en,
   input wire logic edge_sel,
   input wire logic disable_cap,
   // Input and event
   input wire logic capture_pin,
   output logic capture_event
);
   logic [SAMPLES-1:0] hist;
   logic filtered;
   logic prev;
   logic level;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist <= '0;
      end else begin
         hist <= {hist[SAMPLES-2:0], capture_pin};
      end
   end

   // Output moves only after four equal samples
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filtered <= 1'b0;
      end else if (&hist) begin
         filtered <= 1'b1;
      end else if (~|hist) begin
         filtered <= 1'b0;
      end
   end

   assign level = filter_en ? filtered : capture_pin;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 1'b0;
      end else begin
         prev <= level;
      end
   end

   // Edge choice: one rising, zero falling; pin cut off at top
   assign capture_event = !disable_cap &&
      (edge_sel ? (level && !prev) : (!level && prev));
endmodule : capture_filter
`default_nettype wire

// ===== logic/capture_unit.sv
// Capture register and flag setting for one 16-bit timer unit
`timescale 1ns/1ps
`default_nettype none
module capture_unit
   import tmr_irq_pkg::*;
#(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Events in
   input wire logic capture_event,
   input wire logic [WIDTH-1:0] counter_value,
   input wire unit_events_t ev,
   // Results
   output logic [WIDTH-1:0] capture_value,
   output logic [3:0] set_req
);
   // Counter copied on each capture event unless capture is top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_value <= '0;
      end else if (capture_event && !ev.cap_is_top) begin
         capture_value <= counter_value;
      end
   end

   // Order: wrap, match a, match b, capture
   // Match is the registered compare; forced strobes never reach here
   assign set_req[3] = ev.wrap;
   assign set_req[2] = ev.match_a;
   assign set_req[1] = ev.match_b;
   // At top the flag follows the counter, not the pin
   assign set_req[0] = ev.cap_is_top ? ev.at_top : capture_event;
endmodule : capture_unit
`default_nettype wire

// ===== testbench/timer_irq_properties.sv
// Checker: bus timing and interrupt request properties of the flag block
`timescale 1ns/1ps
`default_nettype none
module timer_irq_checker
   import tmr_irq_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Requests and capture
   input wire logic global_irq_en,
   input wire logic [7:0] irq_req,
   input wire logic irq,
   input wire unit_events_t events_u3,
   input wire logic [15:0] top_value_u3
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_follows: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_caused: assert property (pready |-> $past(psel && !penable))
      else $error("ready without setup");
   a_error_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_mapped_ok: assert property (
      psel && !penable && paddr == ADDR_FLAGS |=> !pslverr)
      else $error("error on mapped address");
   a_request_global: assert property (
      |irq_req |-> $past(global_irq_en))
      else $error("request without global enable");
   a_global_quiet: assert property (
      !global_irq_en [*3] |=> irq_req == 8'h00 && !irq)
      else $error("request while globally off");
   a_capture_frozen: assert property (
      events_u3.cap_is_top [*5] |-> $stable(top_value_u3))
      else $error("capture moved while used as top");
endmodule : timer_irq_checker
bind timer_irq_flags timer_irq_checker u_checker (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .global_irq_en(global_irq_en),
   .irq_req(irq_req), .irq(irq), .events_u3(events_u3),
   .top_value_u3(top_value_u3));
`default_nettype wire

// ===== testbench/counter_core_model.sv
// Partner: counter core of one unit, counting and pulsing its events
`timescale 1ns/1ps
`default_nettype none
module counter_core_model
   import tmr_irq_pkg::*;
#(
   parameter logic [15:0] START = 16'h0000
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Commands
   input wire logic run,
   input wire logic [3:0] fire,
   input wire logic cap_top,
   // Outputs
   output logic [15:0] count,
   output unit_events_t ev
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= START;
         ev <= '0;
      end else begin
         if (run) count <= count + 16'h0001;
         // Match pulse already delayed one cycle past equality
         ev <= '{fire[3], fire[2], fire[1], fire[0], cap_top};
      end
   end
endmodule : counter_core_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Testbench: registers, capture, flags and interrupt requests
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import tmr_irq_pkg::*;
;
   localparam logic [15:0] START1 = 16'ha5c3;
   localparam logic [15:0] START3 = 16'h3c5a;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pin1 = 1'b0, pin3 = 1'b1, gie = 1'b0, run1 = 1'b0;
   logic ctop1 = 1'b0, ctop3 = 1'b0, pready, pslverr, irq, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic [3:0] fire1 = 4'h0, fire3 = 4'h0;
   logic [7:0] irq_req, fa, fm;
   logic [15:0] cnt1, cnt3, top1, top3;
   unit_events_t ev1, ev3;
   int fail_count = 0, comparisons = 0, cycles = 0;
   int fpos [8] = '{7, 6, 5, 3, 2, 4, 3, 5};

   timer_irq_flags u_timer_irq_flags (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_pin_u1(pin1), .capture_pin_u3(pin3), .comparator_out(1'b0),
      .counter_value_u1(cnt1), .counter_value_u3(cnt3), .events_u1(ev1),
      .events_u3(ev3), .global_irq_en(gie), .irq_req(irq_req), .irq(irq),
      .top_value_u1(top1), .top_value_u3(top3));
   counter_core_model #(.START(START1)) u_core1 (.pclk(pclk),
      .presetn(presetn), .run(run1), .fire(fire1), .cap_top(ctop1),
      .count(cnt1), .ev(ev1));
   counter_core_model #(.START(START3)) u_core3 (.pclk(pclk),
      .presetn(presetn), .run(1'b0), .fire(fire3), .cap_top(ctop3),
      .count(cnt3), .ev(ev3));

   initial begin
      forever #10 pclk = ~pclk;
   end

   task automatic summarize();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize

   // Hang guard: the whole run needs well under this many cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Held until ready; only the hang guard ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next setup never lands on the release
      @(posedge pclk);
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdata, exp);
   endtask : rd

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_MASK, 32'h0);
      rd(ADDR_MASK_EXT, 32'h0);
      rd(ADDR_FLAGS, 32'h0);
      rd(ADDR_FLAGS_EXT, 32'h0);
      apb(1'b1, ADDR_MASK_EXT, 32'h3c);
      rd(ADDR_MASK_EXT, 32'h3c);
      apb(1'b0, 8'h30, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rdata, 32'h0);
      $display("test done: registers");
      // ---------------------------------------------------------------
      // Capture, edge choice, shared high byte, filter
      // ---------------------------------------------------------------
      apb(1'b1, ADDR_CTRL1, 32'h1);
      pin1 <= 1'b1;
      pin3 <= 1'b0;
      repeat (4) @(posedge pclk);
      rd(ADDR_FLAGS, 32'h8);
      rd(ADDR_FLAGS_EXT, 32'h20);
      rd(ADDR_CAP1_LO, {24'h0, START1[7:0]});
      rd(ADDR_CAP3_HI, {24'h0, START1[15:8]});
      rd(ADDR_CAP3_LO, {24'h0, START3[7:0]});
      rd(ADDR_CAP3_HI, {24'h0, START3[15:8]});
      check({16'h0, top1}, {16'h0, START1});
      check({16'h0, top3}, {16'h0, START3});
      apb(1'b1, ADDR_FLAGS, 32'hff);
      apb(1'b1, ADDR_FLAGS_EXT, 32'hff);
      pin1 <= 1'b0;
      pin3 <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(ADDR_FLAGS, 32'h0);
      rd(ADDR_FLAGS_EXT, 32'h0);
      apb(1'b1, ADDR_CTRL3, 32'h2);
      pin3 <= 1'b0;
      repeat (2) @(posedge pclk);
      pin3 <= 1'b1;
      repeat (8) @(posedge pclk);
      rd(ADDR_FLAGS_EXT, 32'h0);
      pin3 <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(ADDR_FLAGS_EXT, 32'h20);
      apb(1'b1, ADDR_FLAGS_EXT, 32'h20);
      $display("test done: capture");
      // ---------------------------------------------------------------
      // Every flag: set, request, keep on zero write, clear one of two ways
      // ---------------------------------------------------------------
      apb(1'b1, ADDR_MASK, 32'hff);
      apb(1'b1, ADDR_MASK_EXT, 32'hff);
      gie <= 1'b1;
      ctop1 <= 1'b1;
      ctop3 <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         fa = (i < 4) ? ADDR_FLAGS : ADDR_FLAGS_EXT;
         fm = 8'h01 << fpos[i];
         if (i < 4) fire1 <= 4'h8 >> i;
         else fire3 <= 4'h8 >> (i - 4);
         @(posedge pclk);
         fire1 <= 4'h0;
         fire3 <= 4'h0;
         repeat (3) @(posedge pclk);
         check({24'h0, irq_req}, 32'h80 >> i);
         check({31'h0, irq}, 32'h1);
         apb(1'b1, fa, {24'h0, ~fm});
         rd(fa, {24'h0, fm});
         if (!i[0]) apb(1'b1, fa, {24'h0, fm});
         else if (i < 4) apb(1'b1, ADDR_ACK, {24'h0, fm});
         else apb(1'b1, ADDR_ACK, {16'h0, fm, 8'h0});
         rd(fa, 32'h0);
      end
      run1 <= 1'b1;
      pin1 <= 1'b1;
      repeat (6) @(posedge pclk);
      run1 <= 1'b0;
      rd(ADDR_FLAGS, 32'h0);
      rd(ADDR_CAP1_LO, {24'h0, START1[7:0]});
      apb(1'b1, ADDR_MASK, 32'h7f);
      fire1 <= 4'h8;
      @(posedge pclk);
      fire1 <= 4'h0;
      repeat (3) @(posedge pclk);
      check({24'h0, irq_req}, 32'h0);
      rd(ADDR_FLAGS, 32'h80);
      gie <= 1'b0;
      apb(1'b1, ADDR_MASK, 32'hff);
      repeat (2) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      gie <= 1'b1;
      repeat (3) @(posedge pclk);
      check({24'h0, irq_req}, 32'h80);
      $display("test done: interrupts");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
